// ### bench/rtc_control_status_irq_tb_top.sv
// Directed register-level bench for the clock control, status and interrupt block.
// Assumes the crystal tick pulses every cycle so the prescaler runs fast.
`timescale 1ns/100ps
`default_nettype none
module rtc_control_status_irq_tb_top;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, errv, second_tick;
  logic xtal_tick, stop_mode, osc_run_in_stop, irq_req, wake_req, module_active;
  logic [rtcc_pkg::APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv, v1;
  logic [7:0] ext_rdata;
  rtcc_pkg::rtcc_evt_s evt;
  int fails, cmp_count, n;
  logic [11:0] clr_a [4] = '{12'h118, 12'h128, 12'h124, 12'h120};
  logic [31:0] fbit [4] = '{32'h80, 32'h20, 32'h10, 32'h08};
  rtcc_top dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_rdata(ext_rdata), .evt(evt), .second_tick(second_tick),
    .xtal_tick(xtal_tick), .stop_mode(stop_mode), .osc_run_in_stop(osc_run_in_stop),
    .irq_req(irq_req), .wake_req(wake_req), .module_active(module_active));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Starts one edge after entry so back-to-back calls never re-drive psel in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fails++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    evt <= rtcc_pkg::rtcc_evt_s'(4'h8 >> i);
    @(posedge clk);
    evt <= '0;
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    wrap_up();
  end
  initial begin
    {sys_rst, xtal_tick} = 2'b11;
    {psel, penable, pwrite, stop_mode, osc_run_in_stop, paddr, pwdata, evt} = '0;
    ext_rdata = 8'h3C;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    apb(0, 12'h108, 8'h00);
    chk("enables", rdv, 32'h0);
    apb(0, 12'h110, 8'h00);
    chk("flags", rdv, 32'h0);
    apb(1, 12'h108, 8'hA5);
    apb(0, 12'h108, 8'h00);
    chk("enables", rdv, 32'hA5);
    apb(1, 12'h108, 8'h5A);
    apb(0, 12'h200, 8'h00);
    chk("unmapped", {errv, rdv[30:0]}, 32'h80000000);
    apb(1, 12'h10C, 8'h22);
    apb(0, 12'h10C, 8'h00);
    chk("ctrl", rdv, 32'h22);
    apb(1, 12'h10C, 8'h45);
    apb(0, 12'h10C, 8'h00);
    chk("ctrl", rdv, 32'h42);
    apb(1, 12'h10C, 8'hE3);
    apb(0, 12'h10C, 8'h00);
    chk("ctrl", rdv, 32'h62);
    repeat (3200) @(posedge clk);
    apb(0, 12'h138, 8'h00);
    chk("stopwatch", 32'(rdv > 8 && rdv < 12), 32'h1);
    apb(0, 12'h110, 8'h00);
    chk("sw flag", rdv & 32'h40, 32'h40);
    apb(1, 12'h10C, 8'h22);
    apb(0, 12'h138, 8'h00);
    v1 = rdv;
    repeat (640) @(posedge clk);
    apb(0, 12'h138, 8'h00);
    chk("sw hold", rdv, v1);
    apb(1, 12'h10C, 8'hA2);
    apb(0, 12'h138, 8'h00);
    chk("sw clear", rdv, 32'h0);
    apb(0, 12'h108, 8'h00);
    chk("enables", rdv, 32'h5A);
    apb(1, 12'h108, 8'hB8);
    apb(1, 12'h10C, 8'h02);
    pulse(3);
    apb(0, 12'h110, 8'h00);
    chk("off flags", rdv & 32'hB8, 32'h0);
    chk("off active", {31'h0, module_active}, 32'h0);
    apb(1, 12'h10C, 8'h22);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      repeat (3) @(posedge clk);
      chk("irq set", {31'h0, irq_req}, 32'h1);
      apb(0, clr_a[i], 8'h00);
      chk("outside data", rdv, 32'h3C);
      apb(0, 12'h110, 8'h00);
      chk("flag kept", rdv & 32'hB8, fbit[i]);
      apb(0, clr_a[i], 8'h00);
      apb(0, 12'h110, 8'h00);
      chk("flag cleared", rdv & 32'hB8, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq clear", {31'h0, irq_req}, 32'h0);
    end
    apb(1, 12'h108, 8'h08);
    pulse(3);
    stop_mode <= 1'b1;
    repeat (5) @(posedge clk);
    chk("stop wake", {31'h0, wake_req}, 32'h0);
    chk("stop active", {31'h0, module_active}, 32'h0);
    apb(0, 12'h108, 8'h00);
    chk("stop kept", rdv, 32'h08);
    osc_run_in_stop <= 1'b1;
    repeat (5) @(posedge clk);
    chk("osc wake", {31'h0, wake_req}, 32'h1);
    chk("osc active", {31'h0, module_active}, 32'h1);
    stop_mode <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wait wake", {31'h0, wake_req}, 32'h1);
    // Counting is paused so no quarter tick can slip in between the reads
    apb(1, 12'h10C, 8'h02);
    apb(1, 12'h108, 8'h03);
    apb(0, 12'h110, 8'h00);
    apb(0, 12'h138, 8'h00);
    apb(0, 12'h110, 8'h00);
    chk("tb cleared", rdv & 32'h3, 32'h0);
    apb(1, 12'h10C, 8'h22);
    n = 0;
    while (irq_req !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    apb(0, 12'h110, 8'h00);
    chk("quarter", rdv & 32'h1, 32'h1);
    apb(1, 12'h108, 8'h04);
    n = 0;
    while (second_tick !== 1'b1 && n < 33000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    chk("second pulse", {31'h0, second_tick}, 32'h0);
    chk("second irq", {31'h0, irq_req}, 32'h1);
    apb(0, 12'h110, 8'h00);
    chk("second flag", rdv & 32'h7, 32'h7);
    apb(0, 12'h11C, 8'h00);
    apb(0, 12'h110, 8'h00);
    chk("second cleared", rdv & 32'h7, 32'h3);
    // Second reset: crystal select unlocks, then the 128 Hz scaling is checked
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    apb(0, 12'h110, 8'h00);
    chk("reset flags", rdv, 32'h0);
    apb(0, 12'h108, 8'h00);
    chk("reset enables", rdv, 32'h0);
    apb(1, 12'h10C, 8'h60);
    apb(0, 12'h10C, 8'h00);
    chk("ctrl relock", rdv, 32'h60);
    repeat (2600) @(posedge clk);
    apb(0, 12'h138, 8'h00);
    chk("sw 128 Hz", 32'(rdv > 5 && rdv < 9), 32'h1);
    wrap_up();
  end
endmodule
`default_nettype wire

// ### bench/rtcc_props.sv
// Port-level checks for the clock control, status and interrupt block.
// Assumes one clock and a synchronous active-high reset; bound onto rtcc_top.
`timescale 1ns/100ps
`default_nettype none
module rtcc_props (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtcc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Power and status
  input wire logic stop_mode,
  input wire logic osc_run_in_stop,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic module_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Stop without the crystal; the freeze may lag by a register stage
  wire frz = stop_mode && !osc_run_in_stop;
  wire unmapped = (paddr[1:0] != 2'h0) || (paddr[11:10] != 2'h0) ||
                  (paddr[9:2] < 8'h42) || (paddr[9:2] > 8'h4E);
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; !pready ##1 pready; endsequence
  sequence ctrl_off_s; psel && penable && pready && pwrite && paddr == 12'h10C && !pwdata[5];
  endsequence
  a_apb_one_wait: assert property (setup_s |=> answer_s)
    else $error("APB answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer without zero data");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_err_decode: assert property (psel && penable && !pready |=> pslverr == $past(unmapped))
    else $error("error flag does not match address decode");
  a_rst_quiet: assert property (disable iff (1'b0) sys_rst |=> !pready && !irq_req && !wake_req)
    else $error("outputs active after reset");
  a_wake_mask: assert property (frz [*3] |=> !wake_req)
    else $error("wake request while frozen");
  a_frozen_idle: assert property (frz [*4] |-> !module_active)
    else $error("module active while frozen");
  a_wake_mirror: assert property (!frz [*3] |=> wake_req == irq_req)
    else $error("wake request differs from interrupt request");
  a_men_off: assert property (ctrl_off_s |-> ##[1:3] !module_active)
    else $error("module stays active after disable");
endmodule
bind rtcc_top rtcc_props props_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .stop_mode(stop_mode), .osc_run_in_stop(osc_run_in_stop),
  .irq_req(irq_req), .wake_req(wake_req), .module_active(module_active));
`default_nettype wire

// ### include/rtcc_pkg.sv
// Constants and carrier types for the clock control, status and interrupt block.
// Assumes a byte-wide register map reached as 32-bit APB words at four times the index.
package rtcc_pkg;

  // APB address width and register indices (byte address = 4 * index)
  localparam int unsigned APB_AW = 12;
  localparam logic [7:0] IDX_IRQ_EN = 8'h42;
  localparam logic [7:0] IDX_CTRL = 8'h43;
  localparam logic [7:0] IDX_FLAGS = 8'h44;
  localparam logic [7:0] IDX_ALM_MIN = 8'h45;
  localparam logic [7:0] IDX_ALM_HR = 8'h46;
  localparam logic [7:0] IDX_SEC = 8'h47;
  localparam logic [7:0] IDX_MIN = 8'h48;
  localparam logic [7:0] IDX_HR = 8'h49;
  localparam logic [7:0] IDX_DAY = 8'h4A;
  localparam logic [7:0] IDX_SWV = 8'h4E;

  // Reset value shared by every register of the block
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Clock control register fields
  localparam int unsigned CTRL_CLR_BIT = 7;
  localparam int unsigned CTRL_SWE_BIT = 6;
  localparam int unsigned CTRL_MEN_BIT = 5;
  localparam int unsigned XSEL_LSB = 0;
  localparam int unsigned XSEL_W = 3;

  // Flag and enable bit positions (same layout in both registers)
  localparam int unsigned F_ALARM = 7;
  localparam int unsigned F_STOPWATCH = 6;
  localparam int unsigned F_DAY = 5;
  localparam int unsigned F_HOUR = 4;
  localparam int unsigned F_MINUTE = 3;
  localparam int unsigned F_SECOND = 2;
  localparam int unsigned F_HALF = 1;
  localparam int unsigned F_QUARTER = 0;
  localparam int unsigned NUM_FLAGS = 8;

  // Register whose read completes the clear sequence of each flag
  typedef logic [NUM_FLAGS-1:0][7:0] rtcc_idx_map_t;
  localparam rtcc_idx_map_t FLAG_CLR_IDX = {
    IDX_ALM_HR, IDX_SWV, IDX_DAY, IDX_HR, IDX_MIN, IDX_SEC, IDX_SWV, IDX_SWV
  };

  // Crystal select codes and prescaler divisors to the fast tick
  localparam logic [2:0] XSEL_32K768 = 3'h0;
  localparam logic [2:0] XSEL_32K000 = 3'h2;
  localparam logic [2:0] XSEL_38K400 = 3'h3;
  localparam int unsigned XSEL_HI_BIT = 2;
  localparam int unsigned XSEL_LO_BIT = 0;
  localparam logic [9:0] DIV_32K768 = 10'h100;
  localparam logic [9:0] DIV_32K000 = 10'h140;
  localparam logic [9:0] DIV_38K400 = 10'h180;
  localparam logic [9:0] DIV_64K000 = 10'h280;
  localparam logic [9:0] DIV_76K800 = 10'h300;

  // Fast ticks per quarter second and the stopwatch scaling
  localparam logic [5:0] QTR_TICKS_128 = 6'h20;
  localparam logic [5:0] QTR_TICKS_100 = 6'h19;
  localparam logic [7:0] SW_TICKS_128 = 8'h80;
  localparam logic [7:0] SW_TICKS_100 = 8'h64;
  localparam logic [13:0] SW_SCALE = 14'h0064;
  localparam int unsigned SW_SHIFT = 7;
  localparam logic [1:0] LAST_QTR = 2'h3;

  // Events coming from the counting registers
  typedef struct packed {
    logic alarm_match;
    logic day_inc;
    logic hour_inc;
    logic minute_inc;
  } rtcc_evt_s;

  // Software-written control state
  typedef struct packed {
    logic stopwatch_enable;
    logic module_enable;
    logic [XSEL_W-1:0] crystal_freq_select;
  } rtcc_ctrl_s;

endpackage

// ### verilog/rtcc_flag_cell.sv
// One status flag with its two-read clear sequence.
// Assumes set and read strobes are single-cycle pulses in the clk domain.
`timescale 1ns/100ps
`default_nettype none
module rtcc_flag_cell (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Events
  input wire logic set_evt,
  input wire logic status_rd,
  input wire logic seen_set,
  input wire logic clear_rd,
  // Flag
  output logic flag
);
  logic armed;
  logic next_flag;
  logic next_armed;

  // A set in the clearing cycle wins
  assign next_flag = set_evt | (flag & ~(armed & clear_rd));
  // Armed only by a status read that returned the flag as set
  assign next_armed = status_rd ? seen_set : (clear_rd ? 1'b0 : armed);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag <= 1'b0;
      armed <= 1'b0;
    end else begin
      flag <= next_flag;
      armed <= next_armed;
    end
  end
endmodule
`default_nettype wire

// ### verilog/rtcc_top.sv
// Control, status and interrupt logic of the calendar clock, with prescaler and stopwatch.
// Assumes an APB master, a synchronous crystal tick pulse and an outside counting block.
//
// Summary of operation
// - In wait mode counting continues; any enabled flag raises the wake request.
// - With oscillator kept in stop, counting continues and enabled flags wake.
// - Stop without oscillator freezes the block; all register contents are kept.
// - Interrupt enable register: eight read/write enables, cleared by reset.
// - Interrupt request while any flag is set with its enable set.
// - Stopwatch clear bit zeroes the stopwatch only, self-clears, reads zero.
// - Stopwatch enable lets the value count hundredths; otherwise it holds.
// - Module enable gates all counting; clearing it keeps register contents.
// - Crystal select field takes only the first write after reset.
// - Crystal select picks prescaler for 32.768, 32, 38.4, 64, 76.8 kHz.
// - Status register shows eight read-only flags, zero after reset.
// - Alarm flag sets on hour/minute match; cleared by status then alarm hour read.
// - Stopwatch flag sets per stopwatch tick; cleared via stopwatch value read.
// - Day flag sets per day increment; cleared via day register read.
// - Hour flag sets per hour increment; cleared via hour register read.
// - Minute flag sets per minute increment; cleared via minute register read.
// - Second flag sets per second; cleared via seconds register read.
// - Half and quarter second flags; cleared via stopwatch value read.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rtcc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtcc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counting registers outside
  input wire logic [7:0] ext_rdata,
  input wire rtcc_pkg::rtcc_evt_s evt,
  output logic second_tick,
  // Crystal and power modes
  input wire logic xtal_tick,
  input wire logic stop_mode,
  input wire logic osc_run_in_stop,
  // Status to the processor
  output logic irq_req,
  output logic wake_req,
  output logic module_active
);

  // Register state
  logic [7:0] irq_en;
  rtcc_pkg::rtcc_ctrl_s ctrl;
  logic xsel_locked;
  logic alarm_q;
  logic [9:0] div_cnt;
  logic [5:0] qtr_cnt;
  logic [1:0] qtr_num;
  logic [7:0] sw_raw;
  logic [7:0] flags;

  // APB decode
  logic access;
  logic done;
  logic wr;
  logic rd;
  logic idx_ok;
  logic [7:0] idx;
  logic mapped;
  logic hit_en;
  logic hit_ctrl;
  logic hit_flags;
  logic hit_swv;
  logic [7:0] rd_byte;
  logic [31:0] next_prdata;

  // Datapath wires
  logic run;
  logic frozen;
  logic tick_en;
  logic is128;
  logic [9:0] divisor;
  logic fast_tick;
  logic [5:0] qtr_len;
  logic [7:0] sw_len;
  logic qtr_wrap;
  logic sec_evt;
  logic half_evt;
  logic chr_evt;
  logic sw_clear;
  logic [13:0] sw_prod;
  logic [6:0] sw_val;
  logic alarm_set;
  logic [7:0] set_vec;
  logic status_rd;
  logic any_irq;

  // Request phases: one wait state so read data comes from a flop
  assign access = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;

  // Byte address is four times the index; lanes 31:8 are unused
  assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign idx = paddr[9:2];
  assign mapped = idx_ok && (idx >= rtcc_pkg::IDX_IRQ_EN) && (idx <= rtcc_pkg::IDX_SWV);
  assign hit_en = idx_ok && (idx == rtcc_pkg::IDX_IRQ_EN);
  assign hit_ctrl = idx_ok && (idx == rtcc_pkg::IDX_CTRL);
  assign hit_flags = idx_ok && (idx == rtcc_pkg::IDX_FLAGS);
  assign hit_swv = idx_ok && (idx == rtcc_pkg::IDX_SWV);

  // Read mux; the clear bit always reads zero
  assign rd_byte = hit_en ? irq_en :
                   hit_ctrl ? {1'b0, ctrl.stopwatch_enable, ctrl.module_enable,
                               2'h0, ctrl.crystal_freq_select} :
                   hit_flags ? flags :
                   hit_swv ? {1'b0, sw_val} :
                   mapped ? ext_rdata : rtcc_pkg::RST_BYTE;
  assign next_prdata = {24'h000000, rd_byte};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access & ~mapped;
      if (access) begin
        prdata <= next_prdata;
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_en <= rtcc_pkg::RST_BYTE;
    end else if (wr && hit_en) begin
      irq_en <= pwdata[7:0];
    end
  end

  // Clock control; crystal select locks after its first write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= '0;
      xsel_locked <= 1'b0;
    end else if (wr && hit_ctrl) begin
      ctrl.stopwatch_enable <= pwdata[rtcc_pkg::CTRL_SWE_BIT];
      ctrl.module_enable <= pwdata[rtcc_pkg::CTRL_MEN_BIT];
      xsel_locked <= 1'b1;
      if (!xsel_locked) begin
        ctrl.crystal_freq_select <= pwdata[rtcc_pkg::XSEL_LSB +: rtcc_pkg::XSEL_W];
      end
    end
  end

  // The clear bit is never stored, so it acts for exactly one cycle
  assign sw_clear = wr & hit_ctrl & pwdata[rtcc_pkg::CTRL_CLR_BIT];

  // Stop without the oscillator freezes everything in place
  assign frozen = stop_mode & ~osc_run_in_stop;
  assign run = ctrl.module_enable & ~frozen;
  assign tick_en = run & xtal_tick;

  // Prescaler selection; the reserved code falls back to the 32.768 kHz divisor
  assign is128 = (ctrl.crystal_freq_select == rtcc_pkg::XSEL_32K768) ||
                 (ctrl.crystal_freq_select == 3'h1);
  assign divisor = ctrl.crystal_freq_select[rtcc_pkg::XSEL_HI_BIT] ?
                   (ctrl.crystal_freq_select[rtcc_pkg::XSEL_LO_BIT] ?
                    rtcc_pkg::DIV_76K800 : rtcc_pkg::DIV_64K000) :
                   (ctrl.crystal_freq_select == rtcc_pkg::XSEL_32K000) ?
                   rtcc_pkg::DIV_32K000 :
                   (ctrl.crystal_freq_select == rtcc_pkg::XSEL_38K400) ?
                   rtcc_pkg::DIV_38K400 : rtcc_pkg::DIV_32K768;
  assign qtr_len = is128 ? rtcc_pkg::QTR_TICKS_128 : rtcc_pkg::QTR_TICKS_100;
  assign sw_len = is128 ? rtcc_pkg::SW_TICKS_128 : rtcc_pkg::SW_TICKS_100;

  // Fast tick at 100 Hz or 128 Hz
  assign fast_tick = tick_en && (div_cnt == divisor - 10'h001);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt <= 10'h000;
    end else if (fast_tick) begin
      div_cnt <= 10'h000;
    end else if (tick_en) begin
      div_cnt <= div_cnt + 10'h001;
    end
  end

  // Quarter-second timebase, halves and whole seconds derived from it
  assign qtr_wrap = fast_tick && (qtr_cnt == qtr_len - 6'h01);
  assign half_evt = qtr_wrap & qtr_num[0];
  assign sec_evt = qtr_wrap && (qtr_num == rtcc_pkg::LAST_QTR);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      qtr_cnt <= 6'h00;
      qtr_num <= 2'h0;
    end else if (qtr_wrap) begin
      qtr_cnt <= 6'h00;
      qtr_num <= qtr_num + 2'h1;
    end else if (fast_tick) begin
      qtr_cnt <= qtr_cnt + 6'h01;
    end
  end

  // Stopwatch raw count; clear has priority and touches nothing else
  assign chr_evt = fast_tick & ctrl.stopwatch_enable;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_raw <= rtcc_pkg::RST_BYTE;
    end else if (sw_clear) begin
      sw_raw <= rtcc_pkg::RST_BYTE;
    end else if (chr_evt) begin
      sw_raw <= (sw_raw == sw_len - 8'h01) ? rtcc_pkg::RST_BYTE : sw_raw + 8'h01;
    end
  end

  // At 128 Hz the raw count is scaled to hundredths before it is shown
  assign sw_prod = 14'(sw_raw) * rtcc_pkg::SW_SCALE;
  assign sw_val = is128 ? sw_prod[13:rtcc_pkg::SW_SHIFT] : sw_raw[6:0];

  // Alarm sets once on entering the match, not every cycle of it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alarm_q <= 1'b0;
    end else if (run) begin
      alarm_q <= evt.alarm_match;
    end
  end
  assign alarm_set = run & evt.alarm_match & ~alarm_q;

  // Flag set sources in register bit order
  assign set_vec[rtcc_pkg::F_ALARM] = alarm_set;
  assign set_vec[rtcc_pkg::F_STOPWATCH] = chr_evt;
  assign set_vec[rtcc_pkg::F_DAY] = run & evt.day_inc;
  assign set_vec[rtcc_pkg::F_HOUR] = run & evt.hour_inc;
  assign set_vec[rtcc_pkg::F_MINUTE] = run & evt.minute_inc;
  assign set_vec[rtcc_pkg::F_SECOND] = sec_evt;
  assign set_vec[rtcc_pkg::F_HALF] = half_evt;
  assign set_vec[rtcc_pkg::F_QUARTER] = qtr_wrap;

  // Arming uses the value actually returned on the bus, not the live flag
  assign status_rd = rd & hit_flags;

  genvar gi;
  generate
    for (gi = 0; gi < rtcc_pkg::NUM_FLAGS; gi = gi + 1) begin : g_flag
      logic clear_rd;
      assign clear_rd = rd && idx_ok && (idx == rtcc_pkg::FLAG_CLR_IDX[gi]);
      rtcc_flag_cell u_cell (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(set_vec[gi]),
        .status_rd(status_rd),
        .seen_set(prdata[gi]),
        .clear_rd(clear_rd),
        .flag(flags[gi])
      );
    end
  endgenerate

  // One level request from every enabled flag
  assign any_irq = |(flags & irq_en);

  // Frozen stop cannot wake on its own; an outside interrupt must end it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
      wake_req <= 1'b0;
      module_active <= 1'b0;
      second_tick <= 1'b0;
    end else begin
      irq_req <= any_irq;
      wake_req <= any_irq & ~frozen;
      module_active <= run;
      second_tick <= sec_evt;
    end
  end

endmodule
`default_nettype wire
